// ---- bench/fcm_bridge_model.sv ----
/*
 * Model of the external H-bridge: four drives to winding current,
 * with a count of cycles in which one leg shorts the rail.
 * Assumes drives are sampled on the design clock.
 */
`timescale 1ns/10ps

module fcm_bridge_model (
    input  wire logic                i_mclk,
    input  wire fcm_pkg::fcm_bridge_s i_drive,
    output logic                     o_fwd,
    output logic                     o_rev,
    output logic [15:0]              o_short_cnt
);
    import fcm_pkg::*;
    // ------------------------------------------------------------------
    // winding current and shoot-through
    // ------------------------------------------------------------------
    // current a to b is forward, b to a reverse
    assign o_fwd = i_drive.a_hi & i_drive.b_lo;
    assign o_rev = i_drive.b_hi & i_drive.a_lo;
    initial o_short_cnt = 16'h0;
    // a real bridge would burn here, so every such cycle is counted
    always @(posedge i_mclk) begin
        if ((i_drive.a_hi & i_drive.a_lo) | (i_drive.b_hi & i_drive.b_lo)) begin
            o_short_cnt <= o_short_cnt + 16'h1;
        end
    end
endmodule

// ---- bench/tb_top.sv ----
/*
 * Self-checking bench of the fan commutator with a bridge model.
 * Assumes short stall counts by parameter and pull-ups on both flag pins.
 */
`timescale 1ns/10ps

module tb_top;
    import fcm_pkg::*;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    localparam int LOCK = 2000;
    localparam int ON   = 100;
    logic        i_mclk  = 1'b0;
    logic        i_reset = 1'b1;
    logic        hall    = 1'b0;
    fcm_mv_t     speed   = 12'h0;
    fcm_mv_t     flr     = 12'hbb8;
    fcm_mv_t     ref_lvl;
    logic        a_lo, b_lo, a_hi, b_hi, fwd, rev;
    logic        tach, tach_oe, stl, stl_oe;
    logic [15:0] shorts;
    int          n_fail     = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    int          n, m1, m2;
    // open-drain pins with pull-ups
    wire         tach_pin  = tach_oe ? tach : 1'b1;
    wire         stall_pin = stl_oe ? stl : 1'b1;
    wire [3:0]   drv = {a_hi, a_lo, b_hi, b_lo};

    fcm_fan_commutator #(.LOCK_CYC(LOCK), .ON_CYC(ON), .RISE_CYC(50)) dut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_hall_pos_above_neg(hall),
        .i_speed_cmd_in(speed), .i_floor_speed_setting(flr),
        .i_tach_out(tach_pin), .i_stall_flag(stall_pin),
        .o_reference_level_out(ref_lvl),
        .o_leg_a_low_drive(a_lo), .o_leg_b_low_drive(b_lo),
        .o_leg_a_high_drive(a_hi), .o_leg_b_high_drive(b_hi),
        .o_tach_out(tach), .o_tach_out_oe(tach_oe),
        .o_stall_flag(stl), .o_stall_flag_oe(stl_oe));
    fcm_bridge_model bridge (.i_mclk(i_mclk), .i_drive(fcm_bridge_s'(drv)),
        .o_fwd(fwd), .o_rev(rev), .o_short_cnt(shorts));

    always #2 i_mclk = ~i_mclk;
    // hang guard, well above the roughly 30k cycles of the run
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            finish_test();
        end
    end
    // ------------------------------------------------------------------
    // tasks and expectation
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge i_mclk);
    endtask
    task automatic check_bit(input logic e, input logic g);
        num_checks++;
        if (e !== g) begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic check_val(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // legs as chosen by hall; lo_on tells whether the chop is fully on
    task automatic check_legs(input logic lo_on);
        check_bit(hall, a_hi);
        check_bit(~hall, b_hi);
        check_bit(hall & lo_on, b_lo);
        check_bit(~hall & lo_on, a_lo);
        check_bit(hall & lo_on, fwd);
        check_bit(~hall & lo_on, rev);
    endtask
    // level after the floor clamp; a floor at reference imposes nothing
    function automatic int eff_lvl(input int s, input int f);
        return (f < 3000 && f < s) ? f : s;
    endfunction
    // 0 off, 1 full, 2 chopped, from the clamped level
    function automatic int chop_class(input int s, input int f);
        int e;
        e = eff_lvl(s, f);
        return (e >= 3000) ? 0 : ((e <= 1000) ? 1 : 2);
    endfunction
    // linear duty, 3 V none and 1 V all, over a window of two chop periods
    function automatic int duty_exp(input int e);
        return (1536 * (3000 - e)) / 2000;
    endfunction
    // the hall flip keeps the stall timer from running out
    task automatic measure(input int s, input int f, output int on_n);
        speed = s[11:0];
        flr = f[11:0];
        hall = ~hall;
        tick(12);
        on_n = 0;
        repeat (1536) begin
            tick(1);
            on_n += ((hall ? b_lo : a_lo) === 1'b1) ? 1 : 0;
        end
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    int sp[10] = '{0, 1000, 3000, 3500, 3500, 3500, 2000, 4095, 0, 0};
    int fl[10] = '{3000, 3000, 3000, 3000, 1000, 3500, 3000, 2000, 3000, 3000};
    initial begin
        void'($urandom(32'h10d0));
        tick(11);
        check_val(16'h0, {12'h0, drv});
        check_bit(1'b0, stall_pin);
        tick(1);
        i_reset = 1'b0;
        tick(1);
        check_val(16'h0bb8, {4'h0, ref_lvl});
        // chop levels, the last two random inside the span
        sp[8] = $urandom_range(1100, 2900);
        sp[9] = $urandom_range(1100, 2900);
        for (int i = 0; i < 10; i++) begin
            measure(sp[i], fl[i], n);
            case (chop_class(sp[i], fl[i]))
                0: check_val(16'h0, n[15:0]);
                1: check_val(16'd1536, n[15:0]);
                default: begin
                    check_bit(1'b1, n > 0 && n < 1536);
                    m1 = duty_exp(eff_lvl(sp[i], fl[i]));
                    check_bit(1'b1, n >= m1 - 8 && n <= m1 + 8);
                end
            endcase
        end
        measure(1500, 3000, m1);
        measure(2500, 3000, m2);
        check_bit(1'b1, m1 > m2);
        // random commutation with dead band; every step is a real hall edge
        for (int i = 0; i < 24; i++) begin
            speed = (i < 20) ? 12'h0 : 12'hdac;
            hall = ~hall;
            tick(5);
            check_val(16'h0, {12'h0, drv});
            tick(5 + $urandom_range(0, 20));
            check_legs(i < 20);
            check_bit(hall, tach_pin);
        end
        // edges inside the detect time keep the rotor running
        speed = 12'h0;
        repeat (3) begin
            hall = ~hall;
            tick(LOCK - 5);
            check_bit(1'b0, stall_pin);
        end
        n = 0;
        while (stall_pin !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check_bit(1'b1, n >= 2 && n <= 12);
        tick(2);
        check_val(16'h0, {12'h0, drv});
        // two pause and attempt rounds
        repeat (2) begin
            n = 2;
            while (drv === 4'h0 && n < 3000) begin
                tick(1);
                n++;
            end
            check_bit(1'b1, n >= 12 * ON - 3 && n <= 12 * ON + 3);
            check_bit(1'b1, stall_pin);
            n = 0;
            while (drv !== 4'h0 && n < 500) begin
                tick(1);
                n++;
            end
            check_bit(1'b1, n >= ON - 3 && n <= ON + 3);
        end
        hall = ~hall;
        tick(3);
        check_bit(1'b0, stall_pin);
        tick(12);
        check_legs(1'b1);
        check_val(16'h0, shorts);
        finish_test();
    end
endmodule

// ---- verilog/fcm_chop.sv ----
/*
 * Chop generator: triangle ramp between the two thresholds, compared
 * against the effective speed level to give the low-side chop enable.
 * Assumes a level already clamped by the caller, in millivolts.
 */
`timescale 1ns/10ps
`include "fcm_params.svh"

module fcm_chop #(
    parameter int RISE_CYC = `FCM_CHOP_RISE_CYC,
    parameter int FALL_CYC = `FCM_CHOP_FALL_CYC
) (
    input  wire logic           i_mclk,
    input  wire logic           i_reset,
    input  wire fcm_pkg::fcm_mv_t i_level,
    output logic                o_chop_on
);
    import fcm_pkg::*;

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        rising;
    logic        next_rising;
    logic        next_chop_on;

    // ramp above level, in time terms to avoid a divider per cycle
    function automatic logic ramp_above(input int pos, input int len, input fcm_mv_t lvl);
        int excess;
        excess = int'(lvl) - int'(`FCM_VTHL_MV);
        return (pos * `FCM_SPAN_MV) > (excess * len);
    endfunction

    // ----------------------------------------------------------------------
    // ramp and compare
    // ----------------------------------------------------------------------
    // period is rise plus fall phase [R06] [R07]
    always_comb begin
        next_cnt    = cnt + 16'h0001;
        next_rising = rising;
        if (rising && cnt == 16'(RISE_CYC - 1)) begin // [R07]
            next_cnt    = 16'h0000;
            next_rising = 1'b0;
        end else if (!rising && cnt == 16'(FALL_CYC - 1)) begin // [R07]
            next_cnt    = 16'h0000;
            next_rising = 1'b1;
        end
        if (i_level <= `FCM_VTHL_MV) begin
            next_chop_on = 1'b1; // [R04]
        end else if (i_level >= `FCM_VTHH_MV) begin
            next_chop_on = 1'b0; // [R03]
        end else if (rising) begin
            next_chop_on = ramp_above(int'(cnt), RISE_CYC, i_level); // [R02]
        end else begin
            next_chop_on = ramp_above(FALL_CYC - int'(cnt), FALL_CYC, i_level); // [R02]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cnt       <= 16'h0000;
            rising    <= 1'b1;
            o_chop_on <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            rising    <= next_rising;
            o_chop_on <= next_chop_on;
        end
    end

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    a_full_drive: assert property (i_level <= `FCM_VTHL_MV |=> o_chop_on) // [R04]
        else $error("full drive level did not give continuous chop on");
    a_drive_off: assert property (i_level >= `FCM_VTHH_MV |=> !o_chop_on) // [R03]
        else $error("zero drive level left chop on");
    a_ramp_wrap: assert property (rising && cnt == 16'(RISE_CYC - 1) |=> !rising && cnt == 0) // [R07]
        else $error("rise phase did not end on its count");
    c_chop_pulse: cover property (!o_chop_on ##1 o_chop_on ##1 o_chop_on);
endmodule

// ---- verilog/fcm_fan_commutator.sv ----
/*
 * Single-phase fan commutator: Hall-selected bridge leg, low-side chop,
 * minimum-speed clamp, locked-rotor supervisor with restart, tach output.
 * Assumes all inputs synchronous to i_mclk and analog levels as mV codes.
 */
// Function
// [R01] hall positive above negative selects leg B
// [R02] speed 3V zero drive, 1V full
// [R03] speed above 3V turns chop off
// [R04] speed at ground gives continuous drive
// [R05] speed clamped to floor unless floor=reference
// [R06] chop rate set by ramp capacitor
// [R07] chop period is rise plus fall
// [R08] no rotation for detect time: flag, outputs off
// [R09] pause, then drive again for attempt time
// [R10] pause/attempt repeats until rotation returns
// [R11] stall flag open drain, high when stopped
// [R12] tach is open-drain copy of hall
// [R13] active leg low side carries chop
// [R14] inactive leg low side held low
// [R15] high sides follow commutation, never chop
// [R16] attempt to pause ratio one to twelve
// [R17] every hall edge restarts stall timer
// [R18] never both sides of one leg on
`timescale 1ns/10ps
`include "fcm_params.svh"

module fcm_fan_commutator #(
    parameter int LOCK_CYC = `FCM_STALL_DET_CYC,
    parameter int ON_CYC   = `FCM_RESTART_ON_CYC,
    parameter int RISE_CYC = `FCM_CHOP_RISE_CYC
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic             i_hall_pos_above_neg,
    input  wire fcm_pkg::fcm_mv_t i_speed_cmd_in,
    input  wire fcm_pkg::fcm_mv_t i_floor_speed_setting,
    input  wire logic             i_tach_out,
    input  wire logic             i_stall_flag,
    output fcm_pkg::fcm_mv_t      o_reference_level_out,
    output logic                  o_leg_a_low_drive,
    output logic                  o_leg_b_low_drive,
    output logic                  o_leg_a_high_drive,
    output logic                  o_leg_b_high_drive,
    output logic                  o_tach_out,
    output logic                  o_tach_out_oe,
    output logic                  o_stall_flag,
    output logic                  o_stall_flag_oe
);
    import fcm_pkg::*;

    localparam int OFF_CYC = `FCM_OFF_RATIO * ON_CYC; // [R16]

    logic                  hall_q;
    logic                  hall_edge;
    logic [3:0]            dead_cnt;
    logic [3:0]            next_dead_cnt;
    fcm_stall_e            state;
    fcm_stall_e            next_state;
    logic [`FCM_CNT_W-1:0] cnt;
    logic [`FCM_CNT_W-1:0] next_cnt;
    fcm_bridge_s           bridge;
    fcm_bridge_s           next_bridge;
    logic                  next_tach_oe;
    logic                  next_stall_oe;
    fcm_mv_t               eff_level;
    logic                  chop_on;

    // the pin inputs only mirror our own pull-downs; nothing depends on them
    assign o_reference_level_out = `FCM_REF_MV;
    assign o_tach_out            = 1'b0;
    assign o_stall_flag          = 1'b0;
    assign o_leg_a_high_drive    = bridge.a_hi;
    assign o_leg_a_low_drive     = bridge.a_lo;
    assign o_leg_b_high_drive    = bridge.b_hi;
    assign o_leg_b_low_drive     = bridge.b_lo;

    // ----------------------------------------------------------------------
    // speed level and chop
    // ----------------------------------------------------------------------
    // floor at reference means no minimum speed
    always_comb begin
        eff_level = i_speed_cmd_in;
        if (i_floor_speed_setting < `FCM_REF_MV && i_speed_cmd_in > i_floor_speed_setting) begin
            eff_level = i_floor_speed_setting; // [R05]
        end
    end

    fcm_chop #(
        .RISE_CYC (RISE_CYC),
        .FALL_CYC (`FCM_CHOP_FALL_CYC)
    ) u_chop (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_level   (eff_level),
        .o_chop_on (chop_on)
    );

    // ----------------------------------------------------------------------
    // commutation tracking and dead band
    // ----------------------------------------------------------------------
    assign hall_edge = i_hall_pos_above_neg ^ hall_q;

    // dead band keeps old and new leg from overlapping at a hall change
    always_comb begin
        next_dead_cnt = dead_cnt;
        if (hall_edge) begin
            next_dead_cnt = 4'(`FCM_DEAD_CYC); // [R18]
        end else if (dead_cnt != 4'h0) begin
            next_dead_cnt = dead_cnt - 4'h1;
        end
        next_tach_oe = !i_hall_pos_above_neg; // [R12]
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            hall_q        <= 1'b0;
            dead_cnt      <= 4'h0;
            o_tach_out_oe <= 1'b0;
        end else begin
            hall_q        <= i_hall_pos_above_neg;
            dead_cnt      <= next_dead_cnt;
            o_tach_out_oe <= next_tach_oe;
        end
    end

    // ----------------------------------------------------------------------
    // locked-rotor supervisor
    // ----------------------------------------------------------------------
    // any hall edge means the rotor turns, from whatever state
    always_comb begin
        next_state = state;
        next_cnt   = cnt + `FCM_CNT_W'(1);
        case (state)
            fcm_run: begin
                if (hall_edge) begin
                    next_cnt = '0; // [R17]
                end else if (cnt == `FCM_CNT_W'(LOCK_CYC - 1)) begin
                    next_state = fcm_pause; // [R08]
                    next_cnt   = '0;
                end
            end
            fcm_pause: begin
                if (hall_edge) begin
                    next_state = fcm_run; // [R10]
                    next_cnt   = '0;
                end else if (cnt == `FCM_CNT_W'(OFF_CYC - 1)) begin
                    next_state = fcm_attempt; // [R09]
                    next_cnt   = '0;
                end
            end
            fcm_attempt: begin
                if (hall_edge) begin
                    next_state = fcm_run; // [R10]
                    next_cnt   = '0;
                end else if (cnt == `FCM_CNT_W'(ON_CYC - 1)) begin
                    next_state = fcm_pause; // [R10]
                    next_cnt   = '0;
                end
            end
            default: begin
                next_state = fcm_run;
                next_cnt   = '0;
            end
        endcase
        next_stall_oe = (next_state == fcm_run); // [R11]
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state           <= fcm_run;
            cnt             <= '0;
            o_stall_flag_oe <= 1'b1;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            o_stall_flag_oe <= next_stall_oe;
        end
    end

    // ----------------------------------------------------------------------
    // bridge drive
    // ----------------------------------------------------------------------
    // opposite high side conducts with the chopped low side, diagonal pair
    always_comb begin
        next_bridge = '0; // [R14]
        if (dead_cnt == 4'h0 && state != fcm_pause) begin // [R08] [R18]
            if (hall_q) begin // [R01]
                next_bridge.a_hi = 1'b1; // [R15]
                next_bridge.b_lo = chop_on; // [R13]
            end else begin
                next_bridge.b_hi = 1'b1; // [R15]
                next_bridge.a_lo = chop_on; // [R13]
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            bridge <= '0;
        end else begin
            bridge <= next_bridge;
        end
    end

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    a_leg_a_exclusive: assert property (!(o_leg_a_high_drive && o_leg_a_low_drive)) // [R18]
        else $error("leg A high and low on together");
    a_leg_b_exclusive: assert property (!(o_leg_b_high_drive && o_leg_b_low_drive)) // [R18]
        else $error("leg B high and low on together");
    // the real hazard is the hand-over, so the low side must wait out the dead band
    a_leg_a_dead: assert property (
        $fell(o_leg_a_high_drive) |-> !o_leg_a_low_drive [*8]) // [R18]
        else $error("leg A low side on inside dead band");
    a_leg_b_dead: assert property (
        $fell(o_leg_b_high_drive) |-> !o_leg_b_low_drive [*8]) // [R18]
        else $error("leg B low side on inside dead band");
    a_inactive_low: assert property ($past(hall_q) |-> !o_leg_a_low_drive) // [R14]
        else $error("inactive leg A low side driven");
    a_high_follows: assert property (
        hall_q && dead_cnt == 0 && state != fcm_pause |=> o_leg_a_high_drive) // [R15]
        else $error("leg A high side not following commutation");
    a_stall_entry: assert property (
        state == fcm_run && !hall_edge && cnt == `FCM_CNT_W'(LOCK_CYC - 1)
        |=> state == fcm_pause && !o_stall_flag_oe ##1 bridge == '0) // [R08]
        else $error("stall not declared or drive not removed");
    a_pause_len: assert property (
        state == fcm_pause && !hall_edge && cnt == `FCM_CNT_W'(OFF_CYC - 1)
        |=> state == fcm_attempt) // [R09]
        else $error("pause did not end in a restart attempt");
    a_attempt_len: assert property (
        state == fcm_attempt && !hall_edge && cnt == `FCM_CNT_W'(ON_CYC - 1)
        |=> state == fcm_pause) // [R10]
        else $error("attempt did not return to pause");
    a_edge_restart: assert property (hall_edge |=> cnt == 0 && state == fcm_run) // [R17]
        else $error("hall edge did not restart stall timer");
    a_tach_copy: assert property (hall_edge |=> o_tach_out_oe == !hall_q) // [R12]
        else $error("tach does not follow hall");
    a_floor_clamp: assert property (
        i_floor_speed_setting < `FCM_REF_MV |-> eff_level <= i_floor_speed_setting) // [R05]
        else $error("speed level above floor setting");

    c_stall: cover property (state == fcm_run ##1 state == fcm_pause);
    c_restart: cover property (state == fcm_attempt ##1 state == fcm_run);
    c_commute: cover property (o_leg_a_high_drive ##[1:20] o_leg_b_high_drive);
endmodule

// ---- verilog/fcm_params.svh ----
/*
 * Constants of the fan commutator: voltage codes, chop ramp timing,
 * stall supervisor timing and commutation dead band.
 * Assumes analog levels arrive as 12-bit millivolt codes and a 4 ns clock.
 */
`ifndef FCM_PARAMS_SVH
`define FCM_PARAMS_SVH

// ----------------------------------------------------------------------
// voltage codes, millivolts
// ----------------------------------------------------------------------
`define FCM_MV_W            12
`define FCM_VTHL_MV         12'h3e8
`define FCM_VTHH_MV         12'hbb8
`define FCM_REF_MV          12'hbb8
`define FCM_SPAN_MV         2000

// ----------------------------------------------------------------------
// clock and chop ramp (times in ns, capacitance in pF, currents in nA)
// ----------------------------------------------------------------------
`define FCM_CLK_NS          4
`define FCM_CHOP_CAP_PF     100
`define FCM_CAP_OFS_PF      15
`define FCM_CHOP_CHG_NA     7600
`define FCM_CHOP_DIS_NA     80000
`define FCM_CHOP_RISE_NS    ((`FCM_SPAN_MV * (`FCM_CHOP_CAP_PF + `FCM_CAP_OFS_PF) * 1000) / `FCM_CHOP_CHG_NA)
`define FCM_CHOP_FALL_NS    ((`FCM_SPAN_MV * (`FCM_CHOP_CAP_PF + `FCM_CAP_OFS_PF) * 1000) / `FCM_CHOP_DIS_NA)
`define FCM_CHOP_RISE_CYC   (`FCM_CHOP_RISE_NS / `FCM_CLK_NS)
`define FCM_CHOP_FALL_CYC   (`FCM_CHOP_FALL_NS / `FCM_CLK_NS)

// ----------------------------------------------------------------------
// stall supervisor
// ----------------------------------------------------------------------
`define FCM_STALL_CAP_PF    1000
`define FCM_LCK_CHG_NA      3000
`define FCM_RESTART_ON_NS   ((`FCM_SPAN_MV * `FCM_STALL_CAP_PF * 1000) / `FCM_LCK_CHG_NA)
`define FCM_RESTART_ON_CYC  (`FCM_RESTART_ON_NS / `FCM_CLK_NS)
`define FCM_STALL_DET_CYC   (`FCM_RESTART_ON_NS / `FCM_CLK_NS)
`define FCM_OFF_RATIO       12
`define FCM_CNT_W           24

// ----------------------------------------------------------------------
// dead band at commutation, least time rounds up
// ----------------------------------------------------------------------
`define FCM_DEAD_NS         32
`define FCM_DEAD_CYC        ((`FCM_DEAD_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)

`endif

// ---- verilog/fcm_pkg.sv ----
/*
 * Types of the fan commutator.
 * Assumes fcm_params.svh is on the include path.
 */
`include "fcm_params.svh"

package fcm_pkg;
    typedef logic [`FCM_MV_W-1:0] fcm_mv_t;

    // stall supervisor states, one-hot
    typedef enum logic [2:0] {
        fcm_run     = 3'h1,
        fcm_pause   = 3'h2,
        fcm_attempt = 3'h4
    } fcm_stall_e;

    // the four bridge drives, active high = transistor on
    typedef struct packed {
        logic a_hi;
        logic a_lo;
        logic b_hi;
        logic b_lo;
    } fcm_bridge_s;
endpackage
